// ===== rtl/bsc_pkg.sv
// constants, opcodes and carriers for the branch, skip and cpu control unit
package bsc_pkg;
	localparam int PC_W   = 20;
	localparam int CYC_W  = 5;
	// instruction lengths in bytes
	localparam logic [2:0] LEN_ONE   = 3'h1;
	localparam logic [2:0] LEN_TWO   = 3'h2;
	localparam logic [2:0] LEN_SHORT = 3'h3;
	localparam logic [2:0] LEN_LONG  = 3'h4;
	// clock counts, not taken / taken
	localparam logic [CYC_W-1:0] CYC_BR_NT   = 5'h03;
	localparam logic [CYC_W-1:0] CYC_BR_T    = 5'h05;
	localparam logic [CYC_W-1:0] CYC_ES_NT   = 5'h04;
	localparam logic [CYC_W-1:0] CYC_ES_T    = 5'h06;
	localparam logic [CYC_W-1:0] CYC_PM_NT   = 5'h06;
	localparam logic [CYC_W-1:0] CYC_PM_T    = 5'h07;
	localparam logic [CYC_W-1:0] CYC_PMES_NT = 5'h07;
	localparam logic [CYC_W-1:0] CYC_PMES_T  = 5'h08;
	localparam logic [CYC_W-1:0] CYC_ONE     = 5'h01;
	localparam logic [CYC_W-1:0] CYC_IRQ_OP  = 5'h04;
	localparam logic [CYC_W-1:0] CYC_STBY    = 5'h03;
	localparam logic [CYC_W-1:0] CYC_BRK     = 5'h05;
	localparam logic [CYC_W-1:0] CYC_RAM_ADD = 5'h03;
	// status word layout
	localparam int PSW_CY = 0;
	localparam int PSW_AC = 1;
	localparam int PSW_Z  = 2;
	localparam int PSW_RBS_LO = 3;
	localparam int PSW_RBS_HI = 4;
	localparam int PSW_IE = 7;
	localparam logic [7:0] PSW_RESET = 8'h00;
	// register map, byte addresses
	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] REG_CTRL        = 8'h00;
	localparam logic [AXI_AW-1:0] REG_STATUS_WORD = 8'h04;
	localparam logic [AXI_AW-1:0] REG_STATE       = 8'h08;
	localparam int CTRL_RAM_FETCH = 0;
	localparam int ST_HALT = 0;
	localparam int ST_STOP = 1;
	localparam int ST_SKIP = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_CYC_LO = 8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		op_branch_if_bit_false, op_branch_test_and_clear,
		op_skip_if_carry, op_skip_if_no_carry, op_skip_if_zero,
		op_skip_if_not_zero, op_skip_if_higher, op_skip_if_not_higher,
		op_bank_select, op_nop, op_irq_enable_op, op_irq_disable_op,
		op_halt, op_stop, op_break_op
	} bsc_op_type;

	typedef enum logic [2:0] {
		form_saddr, form_sfr, form_acc, form_psw, form_hl, form_es_hl
	} bsc_form_type;

	typedef struct packed {
		bsc_op_type      op;
		bsc_form_type    form;
		logic [PC_W-1:0] pc;
		logic [7:0]      short_displacement;
		logic            bit_val;
		logic [2:0]      bit_idx;
		logic [1:0]      bank;
		logic            prog_mem;
		logic [2:0]      length;
	} bsc_insn_type;

	typedef struct packed {
		logic [PC_W-1:0] next_pc;
		logic            taken;
		logic            clear_bit;
		logic            skipped;
		logic            break_req;
	} bsc_result_type;
endpackage : bsc_pkg

// ===== rtl/bsc_exec.sv
// execution unit for bit branches, skips and cpu control instructions
//
// Implementation choices: the address map and register access over AXI4-Lite.
module bsc_exec (
	input  wire logic                         ref_clk,
	input  wire logic                         nrst,
	input  wire logic [bsc_pkg::AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [bsc_pkg::AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  wire logic                         insn_valid,
	output logic                              insn_ready,
	input  wire bsc_pkg::bsc_insn_type        insn,
	input  wire logic                         irq_req,
	output logic                              done,
	output bsc_pkg::bsc_result_type           result,
	output logic [7:0]                        status_word,
	output logic                              halted,
	output logic                              stopped,
	output logic                              standby_release
);
	typedef enum logic [1:0] {st_idle, st_busy, st_halt, st_stop} bsc_state_type;

	bsc_state_type                 state;
	logic [bsc_pkg::CYC_W-1:0]     cnt;
	logic [bsc_pkg::CYC_W-1:0]     last_cyc;
	logic                          skip_pending;
	logic                          ram_fetch;
	bsc_pkg::bsc_op_type           h_op;
	logic [1:0]                    h_bank;
	logic [2:0]                    h_bit_idx;
	logic                          h_psw_clr;
	logic                          h_skip;
	logic                          accept;
	logic                          commit;
	logic                          bit_now;
	logic                          cond;
	logic [2:0]                    len;
	logic [bsc_pkg::PC_W-1:0]      sdisp;
	logic [bsc_pkg::CYC_W-1:0]     base_cyc;
	logic [bsc_pkg::CYC_W-1:0]     next_cyc;
	bsc_pkg::bsc_result_type       next_res;
	logic                          aw_held;
	logic                          w_held;
	logic [bsc_pkg::AXI_AW-1:0]    aw_addr;
	logic [31:0]                   w_data;
	logic                          w_lane0;
	logic                          wr_fire;
	logic                          psw_wr;

	assign insn_ready = (state == st_idle);
	assign accept = insn_valid && insn_ready;
	assign commit = (state == st_busy) && (cnt == '0);
	assign halted = (state == st_halt);
	assign stopped = (state == st_stop);

	// decode the accepted instruction into its result and clock count
	always_comb begin
		next_res = '0;
		cond = 1'b0;
		base_cyc = bsc_pkg::CYC_ONE;
		bit_now = (insn.form == bsc_pkg::form_psw) ?
			status_word[insn.bit_idx] : insn.bit_val;
		len = (insn.form == bsc_pkg::form_acc ||
			insn.form == bsc_pkg::form_hl) ?
			bsc_pkg::LEN_SHORT : bsc_pkg::LEN_LONG;
		sdisp = {{(bsc_pkg::PC_W-8){insn.short_displacement[7]}},
			insn.short_displacement};
		next_res.next_pc = insn.pc + bsc_pkg::PC_W'(bsc_pkg::LEN_TWO);
		case (insn.op)
			bsc_pkg::op_branch_if_bit_false,
			bsc_pkg::op_branch_test_and_clear: begin
				if (insn.op == bsc_pkg::op_branch_if_bit_false) begin
					cond = !bit_now;
				end else begin
					cond = bit_now;
				end
				next_res.taken = cond;
				next_res.next_pc = insn.pc + bsc_pkg::PC_W'(len) +
					(cond ? sdisp : '0);
				next_res.clear_bit = cond &&
					insn.op == bsc_pkg::op_branch_test_and_clear &&
					insn.form != bsc_pkg::form_psw;
				// program memory read only for the bf indirect forms
				if (insn.prog_mem && insn.op == bsc_pkg::op_branch_if_bit_false
					&& insn.form == bsc_pkg::form_es_hl) begin
					base_cyc = cond ? bsc_pkg::CYC_PMES_T :
						bsc_pkg::CYC_PMES_NT;
				end else if (insn.prog_mem &&
					insn.op == bsc_pkg::op_branch_if_bit_false &&
					insn.form == bsc_pkg::form_hl) begin
					base_cyc = cond ? bsc_pkg::CYC_PM_T :
						bsc_pkg::CYC_PM_NT;
				end else if (insn.form == bsc_pkg::form_es_hl) begin
					base_cyc = cond ? bsc_pkg::CYC_ES_T :
						bsc_pkg::CYC_ES_NT;
				end else begin
					base_cyc = cond ? bsc_pkg::CYC_BR_T :
						bsc_pkg::CYC_BR_NT;
				end
			end
			bsc_pkg::op_skip_if_carry: begin
				cond = status_word[bsc_pkg::PSW_CY];
			end
			bsc_pkg::op_skip_if_no_carry: begin
				cond = !status_word[bsc_pkg::PSW_CY];
			end
			bsc_pkg::op_skip_if_zero: begin
				cond = status_word[bsc_pkg::PSW_Z];
			end
			bsc_pkg::op_skip_if_not_zero: begin
				cond = !status_word[bsc_pkg::PSW_Z];
			end
			bsc_pkg::op_skip_if_higher: begin
				cond = !(status_word[bsc_pkg::PSW_Z] ||
					status_word[bsc_pkg::PSW_CY]);
			end
			bsc_pkg::op_skip_if_not_higher: begin
				cond = status_word[bsc_pkg::PSW_Z] ||
					status_word[bsc_pkg::PSW_CY];
			end
			bsc_pkg::op_bank_select: begin
				base_cyc = bsc_pkg::CYC_ONE;
			end
			bsc_pkg::op_irq_enable_op, bsc_pkg::op_irq_disable_op: begin
				next_res.next_pc = insn.pc +
					bsc_pkg::PC_W'(bsc_pkg::LEN_SHORT);
				base_cyc = bsc_pkg::CYC_IRQ_OP;
			end
			bsc_pkg::op_halt, bsc_pkg::op_stop: begin
				base_cyc = bsc_pkg::CYC_STBY;
			end
			bsc_pkg::op_break_op: begin
				next_res.break_req = 1'b1;
				base_cyc = bsc_pkg::CYC_BRK;
			end
			default: begin
				next_res.next_pc = insn.pc +
					bsc_pkg::PC_W'(bsc_pkg::LEN_ONE);
			end
		endcase
		// a pending skip swallows this instruction whole
		if (skip_pending) begin
			next_res = '0;
			next_res.skipped = 1'b1;
			next_res.next_pc = insn.pc +
				bsc_pkg::PC_W'(insn.length);
			base_cyc = bsc_pkg::CYC_ONE;
		end
		// one count is one ref_clk period; ram fetch stretches it
		next_cyc = ram_fetch ? bsc_pkg::CYC_W'({base_cyc, 1'b0} +
			bsc_pkg::CYC_RAM_ADD) : base_cyc;
	end

	// sequencer: idle, counting clocks, and the two standby modes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= st_idle;
			cnt <= '0;
		end else begin
			case (state)
				st_idle: begin
					if (accept) begin
						state <= st_busy;
						cnt <= next_cyc - bsc_pkg::CYC_ONE;
					end
				end
				st_busy: begin
					if (commit) begin
						if (h_op == bsc_pkg::op_halt) begin
							state <= st_halt;
						end else if (h_op == bsc_pkg::op_stop) begin
							state <= st_stop;
						end else begin
							state <= st_idle;
						end
					end else begin
						cnt <= cnt - bsc_pkg::CYC_ONE;
					end
				end
				st_halt, st_stop: begin
					if (irq_req) begin
						state <= st_idle;
					end
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	// latch the result and the effects still to be committed
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			result <= '0;
			last_cyc <= '0;
			h_op <= bsc_pkg::op_nop;
			h_bank <= '0;
			h_bit_idx <= '0;
			h_psw_clr <= 1'b0;
			h_skip <= 1'b0;
		end else if (accept) begin
			result <= next_res;
			last_cyc <= next_cyc;
			h_op <= skip_pending ? bsc_pkg::op_nop : insn.op;
			h_bank <= insn.bank;
			h_bit_idx <= insn.bit_idx;
			h_psw_clr <= !skip_pending && next_res.taken &&
				insn.op == bsc_pkg::op_branch_test_and_clear &&
				insn.form == bsc_pkg::form_psw;
			h_skip <= !skip_pending && cond && insn.op >=
				bsc_pkg::op_skip_if_carry && insn.op <=
				bsc_pkg::op_skip_if_not_higher;
		end
	end

	// done and release pulses
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			done <= 1'b0;
			standby_release <= 1'b0;
		end else begin
			done <= commit;
			standby_release <= (halted || stopped) && irq_req;
		end
	end

	// skip flag: set by a true skip, cleared by the swallowed instruction
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			skip_pending <= 1'b0;
		end else if (commit && h_skip) begin
			skip_pending <= 1'b1;
		end else if (accept) begin
			skip_pending <= 1'b0;
		end
	end

	// status word: committed instruction wins over a software write
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			status_word <= bsc_pkg::PSW_RESET;
		end else if (commit) begin
			case (h_op)
				bsc_pkg::op_irq_enable_op: begin
					status_word[bsc_pkg::PSW_IE] <= 1'b1;
				end
				bsc_pkg::op_irq_disable_op: begin
					status_word[bsc_pkg::PSW_IE] <= 1'b0;
				end
				bsc_pkg::op_bank_select: begin
					status_word[bsc_pkg::PSW_RBS_HI:bsc_pkg::PSW_RBS_LO]
						<= h_bank;
				end
				bsc_pkg::op_branch_test_and_clear: begin
					if (h_psw_clr) begin
						status_word[h_bit_idx] <= 1'b0;
					end
				end
				default: begin
				end
			endcase
		end else if (psw_wr) begin
			status_word <= w_data[7:0];
		end
	end

	// axi write channel: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign psw_wr = wr_fire && w_lane0 &&
		aw_addr == bsc_pkg::REG_STATUS_WORD;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_lane0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= bsc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == bsc_pkg::REG_CTRL ||
					aw_addr == bsc_pkg::REG_STATUS_WORD ||
					aw_addr == bsc_pkg::REG_STATE) ?
					bsc_pkg::RESP_OKAY : bsc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control register: ram fetch timing select
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ram_fetch <= 1'b0;
		end else if (wr_fire && w_lane0 && aw_addr == bsc_pkg::REG_CTRL) begin
			ram_fetch <= w_data[bsc_pkg::CTRL_RAM_FETCH];
		end
	end

	// axi read channel: one-cycle registered answer
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= bsc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= '0;
			s_axi_rresp <= bsc_pkg::RESP_OKAY;
			case (s_axi_araddr)
				bsc_pkg::REG_CTRL: begin
					s_axi_rdata[bsc_pkg::CTRL_RAM_FETCH] <= ram_fetch;
				end
				bsc_pkg::REG_STATUS_WORD: begin
					s_axi_rdata[7:0] <= status_word;
				end
				bsc_pkg::REG_STATE: begin
					s_axi_rdata[bsc_pkg::ST_HALT] <= halted;
					s_axi_rdata[bsc_pkg::ST_STOP] <= stopped;
					s_axi_rdata[bsc_pkg::ST_SKIP] <= skip_pending;
					s_axi_rdata[bsc_pkg::ST_BUSY] <= (state == st_busy);
					s_axi_rdata[bsc_pkg::ST_CYC_LO+:bsc_pkg::CYC_W] <= last_cyc;
				end
				default: begin
					s_axi_rresp <= bsc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks on the instruction results and timing
	chk_bf_target: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && !skip_pending && insn.op == bsc_pkg::op_branch_if_bit_false
		&& insn.form == bsc_pkg::form_acc && !insn.bit_val |=>
		result.taken && result.next_pc == $past(insn.pc) + 20'h3 +
		{{12{$past(insn.short_displacement[7])}},
		$past(insn.short_displacement)})
		else $error("bit branch target wrong");
	chk_branch_test_and_clear_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && !skip_pending && insn.form == bsc_pkg::form_saddr &&
		insn.op == bsc_pkg::op_branch_test_and_clear |=>
		result.clear_bit == $past(insn.bit_val) &&
		result.taken == $past(insn.bit_val))
		else $error("test and clear wrong");
	chk_flags_kept: assert property (@(posedge ref_clk) disable iff (!nrst)
		commit && h_op == bsc_pkg::op_branch_test_and_clear && !h_psw_clr
		|=> $stable(status_word))
		else $error("flags changed by test and clear");
	chk_branch_time: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && !skip_pending && !ram_fetch && !insn.prog_mem &&
		insn.op == bsc_pkg::op_branch_if_bit_false &&
		insn.form == bsc_pkg::form_saddr && !insn.bit_val |=>
		(state == st_busy)[*5] ##1 done)
		else $error("taken branch time wrong");
	chk_pm_time: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && !skip_pending && !ram_fetch && insn.prog_mem &&
		insn.op == bsc_pkg::op_branch_if_bit_false &&
		insn.form == bsc_pkg::form_hl && insn.bit_val |=>
		(state == st_busy)[*6] ##1 done)
		else $error("program memory branch time wrong");
	chk_skip_carry: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && !skip_pending && !ram_fetch &&
		insn.op == bsc_pkg::op_skip_if_carry
		|-> ##2 skip_pending == $past(status_word[bsc_pkg::PSW_CY], 2))
		else $error("carry skip wrong");
	chk_skip_higher: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && !skip_pending && !ram_fetch &&
		insn.op == bsc_pkg::op_skip_if_higher &&
		status_word[bsc_pkg::PSW_Z] |-> ##2 !skip_pending)
		else $error("higher skip wrong");
	chk_skip_swallow: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && skip_pending |=> result.skipped && !result.clear_bit &&
		result.next_pc == $past(insn.pc) + 20'($past(insn.length)))
		else $error("skipped instruction had effect");
	chk_bank_select: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && !skip_pending && !ram_fetch &&
		insn.op == bsc_pkg::op_bank_select |-> ##2
		status_word[4:3] == $past(insn.bank, 2))
		else $error("bank select wrong");
	chk_irq_enable: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && !skip_pending && !ram_fetch &&
		insn.op == bsc_pkg::op_irq_enable_op |=> (state == st_busy)[*4]
		##1 status_word[bsc_pkg::PSW_IE])
		else $error("irq enable wrong");
	chk_standby_entry: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && !skip_pending && !ram_fetch && insn.op == bsc_pkg::op_halt
		|=> (state == st_busy)[*3] ##1 halted)
		else $error("halt entry wrong");
	chk_standby_exit: assert property (@(posedge ref_clk) disable iff (!nrst)
		(halted || stopped) && irq_req |=> insn_ready && standby_release)
		else $error("standby not released");
	chk_ram_time: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && ram_fetch && skip_pending |=> (state == st_busy)[*5]
		##1 done)
		else $error("ram fetch time wrong");
	chk_break_raise: assert property (@(posedge ref_clk) disable iff (!nrst)
		accept && !skip_pending && insn.op == bsc_pkg::op_break_op
		|=> result.break_req)
		else $error("break not raised");
endmodule : bsc_exec

// ===== verif/bsc_exec_tb_top.sv
// self-checking bench for the branch, skip and cpu control unit
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module bsc_exec_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    ref_clk = 1'b0;
	logic                    nrst = 1'b0;
	logic [7:0]              awaddr = '0, araddr = '0;
	logic [31:0]             wdata = '0, rdata;
	logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                    arvalid = 1'b0, rready = 1'b0, irq_req = 1'b0;
	logic                    awready, wready, bvalid, arready, rvalid;
	logic [1:0]              bresp, rresp, rsp;
	logic                    insn_valid = 1'b0, insn_ready, done;
	logic                    halted, stopped, standby_release;
	bsc_pkg::bsc_insn_type   insn = '0;
	bsc_pkg::bsc_result_type result;
	logic [7:0]              status_word;
	logic [31:0]             d;
	int                      n_errors = 0, cmp_count = 0, n, i;
	// free-running cpu clock, 40 ns period
	always #20 ref_clk = ~ref_clk;
	bsc_exec uut (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .insn_valid(insn_valid), .insn_ready(insn_ready),
		.insn(insn), .irq_req(irq_req), .done(done), .result(result),
		.status_word(status_word), .halted(halted), .stopped(stopped),
		.standby_release(standby_release));
	// verdict and end of run
	task automatic finish_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	// a wait that ran out ends the run
	task automatic bail(input int k, input int lim);
		if (k >= lim) begin
			n_errors++;
			finish_test();
		end
	endtask : bail
	// one axi write, address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		logic aw_t, w_t, b_t;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge ref_clk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			rsp = bresp;
			@(posedge ref_clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t) begin
				bready <= 1'b0;
				break;
			end
		end
		bail(i, 50);
	endtask : axi_wr
	// one axi read, result in d and rsp
	task automatic axi_rd(input logic [7:0] a);
		logic ar_t, r_t;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge ref_clk);
			ar_t = arvalid && arready;
			r_t = rvalid;
			d = rdata;
			rsp = rresp;
			@(posedge ref_clk);
			if (ar_t) arvalid <= 1'b0;
			if (r_t) begin
				rready <= 1'b0;
				break;
			end
		end
		bail(i, 50);
	endtask : axi_rd
	// offer one instruction at pc 0x01000, n counts edges to done
	task automatic run(input bsc_pkg::bsc_op_type op,
		input bsc_pkg::bsc_form_type f, input logic bv,
		input logic [2:0] bi, input logic [1:0] bk, input logic pm);
		logic rdy;
		@(posedge ref_clk);
		insn <= '{op: op, form: f, pc: 20'h01000, short_displacement: 8'hf0,
			bit_val: bv, bit_idx: bi, bank: bk, prog_mem: pm, length: 3'h2};
		insn_valid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge ref_clk);
			rdy = insn_ready;
			@(posedge ref_clk);
			if (rdy) break;
		end
		insn_valid <= 1'b0;
		for (n = 0; n < 60; n++) begin
			@(posedge ref_clk);
			@(negedge ref_clk);
			if (done) break;
		end
		bail(i, 50);
		bail(n, 60);
		n = n + 1;
	endtask : run
	// main sequence
	initial begin
		logic [2:0] len;
		logic tk, sk, ps, z, c;
		logic [5:0] cv;
		int cy;
		bsc_pkg::bsc_form_type fm;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		axi_rd(bsc_pkg::REG_STATUS_WORD);
		`CHK(d[7:0], bsc_pkg::PSW_RESET)
		axi_rd(8'hfc);
		`CHK({rsp, d}, {bsc_pkg::RESP_SLVERR, 32'h0})
		// bit branches: both ops, every form, both bit values
		for (int o = 0; o < 2; o++) for (int f = 0; f < 6; f++)
		for (int b = 0; b < 2; b++) for (int pm = 0; pm < 2; pm++) begin
			fm = bsc_pkg::bsc_form_type'(f);
			if (pm == 1 && (o == 1 || fm < bsc_pkg::form_hl)) continue;
			axi_wr(bsc_pkg::REG_STATUS_WORD, 32'h01);
			ps = (fm == bsc_pkg::form_psw);
			len = (fm == bsc_pkg::form_acc || fm == bsc_pkg::form_hl) ? 3'h3 : 3'h4;
			run(o ? bsc_pkg::op_branch_test_and_clear : bsc_pkg::op_branch_if_bit_false,
				fm, b[0], b ? 3'h0 : 3'h1, 2'h0, pm[0]);
			tk = (b == o);
			cy = (pm ? 6 : 3) + (fm == bsc_pkg::form_es_hl) + (tk ? 2 - pm : 0);
			`CHK(result.taken, tk)
			`CHK(result.next_pc, 20'h01000 + len - (tk ? 20'h10 : 20'h0))
			`CHK(n, cy)
			`CHK(status_word, (o && ps && b) ? 8'h00 : 8'h01)
			if (o && !ps) `CHK(result.clear_bit, b[0])
		end
		// every skip against carry, zero and neither; then a bank select
		for (int k = 0; k < 6; k++) for (int s = 0; s < 3; s++) begin
			axi_wr(bsc_pkg::REG_STATUS_WORD, {29'h0, s == 2, 1'b0, s == 1});
			c = (s == 1);
			z = (s == 2);
			cv = {z | c, !(z | c), !z, z, !c, c};
			sk = cv[k];
			run(bsc_pkg::bsc_op_type'(k + 2), bsc_pkg::form_saddr, 1'b0, 3'h0,
				2'h0, 1'b0);
			`CHK(n, 1)
			run(bsc_pkg::op_bank_select, bsc_pkg::form_saddr, 1'b0, 3'h0, 2'h3, 1'b0);
			`CHK(result.skipped, sk)
			`CHK(status_word[4:3], sk ? 2'h0 : 2'h3)
			if (sk) `CHK(result.next_pc, 20'h01002)
		end
		for (int k = 0; k < 4; k++) begin
			run(bsc_pkg::op_bank_select, bsc_pkg::form_saddr, 1'b0, 3'h0, k[1:0], 1'b0);
			`CHK({n[3:0], status_word[4:3]}, {4'h1, k[1:0]})
		end
		// global enable set and cleared, then break with interrupts off
		for (int k = 0; k < 2; k++) begin
			run(k ? bsc_pkg::op_irq_disable_op : bsc_pkg::op_irq_enable_op,
				bsc_pkg::form_saddr, 1'b0, 3'h0, 2'h0, 1'b0);
			`CHK({n[3:0], status_word[7]}, {4'h4, k == 0})
		end
		run(bsc_pkg::op_break_op, bsc_pkg::form_saddr, 1'b0, 3'h0, 2'h0, 1'b0);
		`CHK({result.break_req, result.next_pc}, {1'b1, 20'h01002})
		`CHK(n, 5)
		// halt and stop, each ended by a maskable request
		for (int k = 0; k < 2; k++) begin
			run(k ? bsc_pkg::op_stop : bsc_pkg::op_halt, bsc_pkg::form_saddr,
				1'b0, 3'h0, 2'h0, 1'b0);
			`CHK({n[3:0], stopped, halted}, {4'h3, k == 1, k == 0})
			@(posedge ref_clk);
			irq_req <= 1'b1;
			for (i = 0; i < 20; i++) begin
				@(negedge ref_clk);
				if (standby_release === 1'b1) break;
			end
			bail(i, 20);
			@(posedge ref_clk);
			irq_req <= 1'b0;
			@(negedge ref_clk);
			`CHK({stopped, halted}, 2'h0)
		end
		// fetch from ram stretches a 3-clock branch to 9
		axi_wr(bsc_pkg::REG_CTRL, 32'h1);
		`CHK(rsp, bsc_pkg::RESP_OKAY)
		run(bsc_pkg::op_branch_if_bit_false, bsc_pkg::form_saddr, 1'b1, 3'h0,
			2'h0, 1'b0);
		`CHK(n, 9)
		// a skip under ram fetch takes 5 clocks, and so does the swallowed one
		axi_wr(bsc_pkg::REG_STATUS_WORD, 32'h04);
		run(bsc_pkg::op_skip_if_zero, bsc_pkg::form_saddr, 1'b0, 3'h0, 2'h0,
			1'b0);
		`CHK(n, 5)
		run(bsc_pkg::op_bank_select, bsc_pkg::form_saddr, 1'b0, 3'h0, 2'h1,
			1'b0);
		`CHK({n[3:0], result.skipped}, {4'h5, 1'b1})
		`CHK(status_word[4:3], 2'h0)
		finish_test();
	end
endmodule : bsc_exec_tb_top
